// File: logic/flash_overlay_params.svh
`ifndef FLASH_OVERLAY_PARAMS_SVH
`define FLASH_OVERLAY_PARAMS_SVH

// Word address of the whole array: 32M words
`define ADDR_W          25
`define BANK_HI         24
`define BANK_LO         21
`define SECT_HI         24
`define SECT_LO         16
`define SECT_BANK_HI    8
`define SECT_BANK_LO    5
`define BANK_ZERO       4'h0
`define BANK_NONE       16'h0000
`define BANK_ONE        16'h0001

// Command decode
`define CMD_BYTE_LOW    8'hAA
`define DATA_ID_ENTER   8'h90
`define DATA_QRY_ENTER  8'h98
`define DATA_SEC_ENTER  8'h88
`define DATA_CFG_ENTER  8'h37
`define DATA_EXIT       8'hF0
`define DATA_CFG_EXIT   16'h00F0

// Sector-relative byte offsets (128 KB sector, 17 offset bits)
`define OFF_W           17
`define ID_LAST         17'h0001F
`define QRY_LAST        17'h000CE
`define SEC_FACT_LAST   17'h000FF
`define SEC_LAST        17'h001FF

// Identity and query bytes
`define QRY_WORD_Q      8'h10
`define QRY_WORD_R      8'h11
`define QRY_WORD_Y      8'h12
`define ASCII_Q         8'h51
`define ASCII_R         8'h52
`define ASCII_Y         8'h59
`define WORD_MFR        8'h00
`define WORD_DEV        8'h01

`define CFG_RESET       16'hFFFF
`define SECT_RESET      9'h000
`define ZERO_BYTE       8'h00
`define ZERO_WORD       16'h0000

`endif

// File: logic/flash_overlay_pkg.sv
`include "flash_overlay_params.svh"

package flash_overlay_pkg;

    typedef enum logic [1:0]
    {
        MODE_READ,
        MODE_IDQ,
        MODE_SEC,
        MODE_CFG
    } overlay_mode_t;

    // One host bus cycle as seen by the control unit
    typedef struct packed
    {
        logic                 rd;
        logic                 wr;
        logic [`ADDR_W-1:0]   addr;
        logic [15:0]          wdata;
    } host_req_t;

endpackage

// File: logic/flash_sector_overlay_control.sv
`timescale 1ns/1ps
`include "flash_overlay_params.svh"

// How it works
// (R1) Bank-zero write, byte low AAh, data xx98h/xx90h enters identity/query overlay.
// (R2) Identity/query entry accepted only while the addressed bank is in read mode.
// (R3) Identity/query overlay reads in the selected sector return overlay data.
// (R4) While identity/query overlaid, any write of xxF0h returns array reads.
// (R5) Identity bytes sit at sector byte offsets 00000h to 0001Fh.
// (R6) Query structure sits at sector byte offsets 00020h to 000CEh.
// (R7) Each identity/query byte is one word on bits 7:0, upper byte zero.
// (R8) Secure region 512 bytes: factory 0000h-00FFh, customer 0100h-01FFh.
// (R9) Secure region overlays the sector addressed by its entry command.
// (R10) Configuration entry works only when the addressed bank is in read mode.
// (R11) Configuration mode replaces array data in the selected sector.
// (R12) Configuration mode ends on a write of 00F0h anywhere.
// (R13) Sectors are 128 KB, byte base has its low 17 bits zero.
// (R14) Bank is the top four word address bits; one mode_reg for all banks, overlaid bank flagged in overlay_bank_reg.
// (R15) Writes to read-only identity/query locations leave contents unchanged.
// (R16) Entry commands ignored while another bank is in algorithm or overlay mode.
// (R17) Other sectors and other banks keep returning array data.
// (R18) Programs to identity/query or factory secure area fail, data unchanged.
// (R19) After reset every bank is in read mode, no overlay active.
module flash_sector_overlay_control
    import flash_overlay_pkg::*;
#(
    parameter logic [7:0] MFR_CODE = 8'h5A,  // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3C   // Arbitrary value
)
(
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire host_req_t     req,
    input  wire logic [15:0]   array_rdata,
    input  wire logic [15:0]   algo_busy,
    output logic      [15:0]   rdata_reg,
    output logic               rvalid_reg,
    output logic               prog_fail_reg,
    output logic      [15:0]   cfg_word_reg,
    output overlay_mode_t      mode_reg,
    output logic      [8:0]    sector_reg,
    output logic      [15:0]   overlay_bank_reg
);

    logic [3:0]          req_bank;
    logic [8:0]          req_sect;
    logic [`OFF_W-1:0]   byte_off;
    logic                cmd_addr;
    logic                entry_ok;
    logic                in_sector;
    logic                idq_cmd;
    logic                sec_cmd;
    logic                cfg_cmd;
    logic                exit_any;
    logic                cfg_exit;
    overlay_mode_t       mode_next;
    logic [8:0]          sector_next;
    logic [15:0]         rd_word;
    logic [15:0]         cust_mem [128];

    // Identity and query bytes; everything not listed reads as zero
    function automatic logic [7:0] idq_byte(input logic [7:0] w);
        logic [7:0] b;
        b = `ZERO_BYTE;
        unique case (w)
            `WORD_MFR:   b = MFR_CODE;
            `WORD_DEV:   b = DEV_CODE;
            `QRY_WORD_Q: b = `ASCII_Q;
            `QRY_WORD_R: b = `ASCII_R;
            `QRY_WORD_Y: b = `ASCII_Y;
            default:     b = `ZERO_BYTE;
        endcase
        return b;
    endfunction

    // Factory area is mask data here: an index pattern, not programmable
    function automatic logic [15:0] factory_word(input logic [7:0] w);
        return {~w, w};
    endfunction

    assign req_bank  = req.addr[`BANK_HI:`BANK_LO];                       // R14
    assign req_sect  = req.addr[`SECT_HI:`SECT_LO];                       // R13
    assign byte_off  = {req.addr[15:0], 1'b0};                            // R13
    assign cmd_addr  = {req.addr[6:0], 1'b0} == `CMD_BYTE_LOW;
    // Only one overlay at a time, so read mode here means no bank overlaid
    assign entry_ok  = (mode_reg == MODE_READ) && (algo_busy == `BANK_NONE);  // R2 R10 R16
    assign in_sector = req_sect == sector_reg;
    assign idq_cmd   = req.wr && cmd_addr && (req_bank == `BANK_ZERO)
                       && ((req.wdata[7:0] == `DATA_ID_ENTER)
                       || (req.wdata[7:0] == `DATA_QRY_ENTER));           // R1
    assign sec_cmd   = req.wr && cmd_addr && (req.wdata[7:0] == `DATA_SEC_ENTER);
    assign cfg_cmd   = req.wr && cmd_addr && (req.wdata[7:0] == `DATA_CFG_ENTER);
    assign exit_any  = req.wr && (req.wdata[7:0] == `DATA_EXIT);
    assign cfg_exit  = req.wr && (req.wdata == `DATA_CFG_EXIT);

    always_comb
    begin
        mode_next   = mode_reg;
        sector_next = sector_reg;
        unique case (mode_reg)
            MODE_READ:
            begin
                if (entry_ok && idq_cmd)                                  // R1 R2
                begin
                    mode_next   = MODE_IDQ;
                    sector_next = req_sect;
                end
                else if (entry_ok && sec_cmd)                             // R9
                begin
                    mode_next   = MODE_SEC;
                    sector_next = req_sect;
                end
                else if (entry_ok && cfg_cmd)                             // R10
                begin
                    mode_next   = MODE_CFG;
                    sector_next = req_sect;
                end
            end
            MODE_IDQ, MODE_SEC:
            begin
                if (exit_any)                                             // R4
                    mode_next = MODE_READ;
            end
            MODE_CFG:
            begin
                if (cfg_exit)                                             // R12
                    mode_next = MODE_READ;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg         <= MODE_READ;                                // R19
            sector_reg       <= `SECT_RESET;
            overlay_bank_reg <= `BANK_NONE;
        end
        else
        begin
            mode_reg         <= mode_next;
            sector_reg       <= sector_next;
            overlay_bank_reg <= (mode_next == MODE_READ) ? `BANK_NONE
                            : 16'(`BANK_ONE << sector_next[`SECT_BANK_HI:`SECT_BANK_LO]);  // R14
        end
    end

    // Customer area: programming can only clear bits, as in the array
    always_ff @(posedge mclk)
    begin
        if (mode_reg == MODE_SEC && req.wr && !exit_any && in_sector
            && byte_off > `SEC_FACT_LAST && byte_off <= `SEC_LAST)
            cust_mem[req.addr[6:0]] <= cust_mem[req.addr[6:0]] & req.wdata;  // R8
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            prog_fail_reg <= 1'b0;
        else
            prog_fail_reg <= req.wr && !exit_any && in_sector
                             && ((mode_reg == MODE_IDQ && byte_off <= `QRY_LAST)
                             || (mode_reg == MODE_SEC && byte_off <= `SEC_FACT_LAST));  // R15 R18
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_word_reg <= `CFG_RESET;
        else if (mode_reg == MODE_CFG && req.wr && !cfg_exit && in_sector)
            cfg_word_reg <= req.wdata;                                    // R11
    end

    always_comb
    begin
        rd_word = array_rdata;                                            // R17
        if (in_sector)
        begin
            unique case (mode_reg)
                MODE_READ:
                    rd_word = array_rdata;
                MODE_IDQ:                                                 // R3 R5 R6 R7
                    rd_word = (byte_off <= `QRY_LAST)
                              ? {`ZERO_BYTE, idq_byte(req.addr[7:0])} : `ZERO_WORD;
                MODE_SEC:                                                 // R8
                    if (byte_off <= `SEC_FACT_LAST)
                        rd_word = factory_word(req.addr[7:0]);
                    else if (byte_off <= `SEC_LAST)
                        rd_word = cust_mem[req.addr[6:0]];
                    else
                        rd_word = `ZERO_WORD;
                MODE_CFG:
                    rd_word = cfg_word_reg;                               // R11
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= `ZERO_WORD;
        end
        else
        begin
            rvalid_reg <= req.rd;
            rdata_reg  <= req.rd ? rd_word : rdata_reg;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence idq_entry_s;
        mode_reg == MODE_READ && algo_busy == `BANK_NONE && idq_cmd;
    endsequence

    sequence idq_active_s;
        mode_reg == MODE_IDQ;
    endsequence

    idq_enter_a: assert property (idq_entry_s |=> mode_reg == MODE_IDQ      // R1
        && sector_reg == $past(req_sect))
        else $error("identity overlay not entered");
    entry_busy_a: assert property (mode_reg == MODE_READ && algo_busy != `BANK_NONE  // R16
        |=> mode_reg == MODE_READ)
        else $error("entry taken while a bank is busy");
    entry_nested_a: assert property (mode_reg != MODE_READ && !exit_any && !cfg_exit  // R2
        |=> $stable(sector_reg))
        else $error("overlay sector moved while overlaid");
    idq_read_a: assert property (idq_active_s ##0 (req.rd && in_sector)     // R7
        |=> rvalid_reg && rdata_reg[15:8] == `ZERO_BYTE)
        else $error("identity word has nonzero upper byte");
    idq_exit_a: assert property (idq_active_s ##0 exit_any                  // R4
        |=> mode_reg == MODE_READ && overlay_bank_reg == `BANK_NONE)
        else $error("identity overlay did not exit");
    idq_hold_a: assert property (idq_active_s ##0 (req.wr && !exit_any)     // R15
        |=> mode_reg == MODE_IDQ ##0 prog_fail_reg == $past(in_sector && byte_off <= `QRY_LAST))
        else $error("identity write changed state");
    sec_factory_a: assert property (mode_reg == MODE_SEC && req.wr && !exit_any  // R18
        && in_sector && byte_off <= `SEC_FACT_LAST |=> prog_fail_reg)
        else $error("factory program did not fail");
    cfg_exit_a: assert property (mode_reg == MODE_CFG && req.wr             // R12
        |=> (mode_reg == MODE_READ) == ($past(req.wdata) == `DATA_CFG_EXIT))
        else $error("configuration exit decode wrong");
    other_sector_a: assert property (req.rd && (!in_sector || mode_reg == MODE_READ)  // R17
        |=> rdata_reg == $past(array_rdata))
        else $error("array read replaced outside overlay");
    bank_track_a: assert property (mode_reg != MODE_READ                    // R14
        |-> overlay_bank_reg == 16'(`BANK_ONE << sector_reg[`SECT_BANK_HI:`SECT_BANK_LO]))
        else $error("overlay bank flag wrong");

endmodule

// File: bench/flash_array_model.sv
`timescale 1ns/1ps

// Stands in for the flash array behind the overlay logic.
// Each word is address bits 15:0 XOR {bits 24:17, C3h}; bit 16 is unused, so sectors
// 2n and 2n+1 hold the same words, and a leak between them shows only as overlay data.
module flash_array_model
(
    input  wire logic [24:0] addr,
    output logic      [15:0] rdata
);
    assign rdata = addr[15:0] ^ {addr[24:17], 8'hC3};
endmodule

// File: bench/test_flash_sector_overlay_control.sv
`timescale 1ns/1ps

`define CHK(a, e) \
    begin \
        num_checks++; \
        if ((a) !== (e)) \
        begin \
            n_mismatch++; \
            $display("mismatch t=%0t got %h exp %h", $time, a, e); \
        end \
    end

module test_flash_sector_overlay_control
    import flash_overlay_pkg::*;
;
    localparam logic [7:0] MFR = 8'h5A; // Arbitrary value
    localparam logic [7:0] DEV = 8'h3C; // Arbitrary value

    logic          mclk;
    logic          rst_n;
    host_req_t     req;
    logic [15:0]   array_rdata;
    logic [15:0]   algo_busy;
    logic [15:0]   rdata_reg;
    logic          rvalid_reg;
    logic          prog_fail_reg;
    logic [15:0]   cfg_word_reg;
    overlay_mode_t mode_reg;
    logic [8:0]    sector_reg;
    logic [15:0]   overlay_bank_reg;
    logic          pf;
    int            n_mismatch = 0;
    int            num_checks = 0;

    flash_sector_overlay_control #(.MFR_CODE(MFR), .DEV_CODE(DEV)) uut
    (
        .mclk             (mclk),
        .rst_n            (rst_n),
        .req              (req),
        .array_rdata      (array_rdata),
        .algo_busy        (algo_busy),
        .rdata_reg        (rdata_reg),
        .rvalid_reg       (rvalid_reg),
        .prog_fail_reg    (prog_fail_reg),
        .cfg_word_reg     (cfg_word_reg),
        .mode_reg         (mode_reg),
        .sector_reg       (sector_reg),
        .overlay_bank_reg (overlay_bank_reg)
    );

    flash_array_model array_model
    (
        .addr  (req.addr),
        .rdata (array_rdata)
    );

    function automatic logic [15:0] arr(input logic [24:0] a);
        return a[15:0] ^ {a[24:17], 8'hC3};
    endfunction

    // Idle cycle after each request keeps one assignment per time step
    task automatic wr(input logic [24:0] a, input logic [15:0] d);
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        req = '0;
        pf = prog_fail_reg;
        @(posedge mclk);
        #1;
    endtask

    task automatic rd_chk(input logic [24:0] a, input logic [15:0] e);
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge mclk);
        #1;
        req = '0;
        `CHK(rvalid_reg, 1'b1)
        `CHK(rdata_reg, e)
        @(posedge mclk);
        #1;
    endtask

    task automatic t_reset;
        `CHK(mode_reg, MODE_READ)
        `CHK(overlay_bank_reg, 16'h0000)
        `CHK(sector_reg, 9'h000)
        `CHK(rdata_reg, 16'h0000)
        `CHK(cfg_word_reg, 16'hFFFF)
        `CHK({rvalid_reg, prog_fail_reg}, 2'b00)
    endtask

    task automatic t_idq;
        logic [7:0] ent[2] = '{8'h98, 8'h90};
        foreach (ent[i])
        begin
            wr(25'h0000055, {8'h12, ent[i]});
            `CHK(mode_reg, MODE_IDQ)
            `CHK(overlay_bank_reg, 16'h0001)
            rd_chk(25'h0000010, 16'h0051);
            rd_chk(25'h0000000, {8'h00, MFR});
            rd_chk(25'h0000001, {8'h00, DEV});
            rd_chk(25'h0010010, arr(25'h0010010));
            wr(25'h0000010, 16'h00FF);
            `CHK(pf, 1'b1)
            rd_chk(25'h0000010, 16'h0051);
            wr(25'h1234567, 16'h55F0);
            `CHK(mode_reg, MODE_READ)
            rd_chk(25'h0000010, arr(25'h0000010));
        end
    endtask

    task automatic t_refuse;
        wr(25'h0200055, 16'h0098);
        `CHK(mode_reg, MODE_READ)
        algo_busy = 16'h0004;
        wr(25'h0000055, 16'h0098);
        `CHK(mode_reg, MODE_READ)
        algo_busy = 16'h0000;
    endtask

    task automatic t_cfg;
        wr(25'h0620055, 16'h0037);
        `CHK(mode_reg, MODE_CFG)
        `CHK(sector_reg, 9'h062)
        `CHK(overlay_bank_reg, 16'h0008)
        wr(25'h0620100, 16'h1234);
        rd_chk(25'h0621000, 16'h1234);
        rd_chk(25'h0630000, arr(25'h0630000));
        wr(25'h0000055, 16'h0098);
        `CHK(mode_reg, MODE_CFG)
        wr(25'h1F00000, 16'h00F0);
        `CHK(mode_reg, MODE_READ)
        `CHK(cfg_word_reg, 16'h1234)
    endtask

    task automatic t_secure;
        wr(25'h0050055, 16'h0088);
        `CHK(mode_reg, MODE_SEC)
        `CHK(sector_reg, 9'h005)
        rd_chk(25'h0050003, 16'hFC03);
        wr(25'h0050010, 16'h0000);
        `CHK(pf, 1'b1)
        wr(25'h0050080, 16'h0000);
        `CHK(pf, 1'b0)
        rd_chk(25'h0050080, 16'h0000);
        wr(25'h0000000, 16'h00F0);
        `CHK(mode_reg, MODE_READ)
    endtask

    // Reset in mid-run must drop an active overlay and the config word
    task automatic t_rst_mid;
        wr(25'h0000055, 16'h0090);
        `CHK(mode_reg, MODE_IDQ)
        rst_n = 1'b0;
        #1;
        `CHK(mode_reg, MODE_READ)
        `CHK(overlay_bank_reg, 16'h0000)
        `CHK(cfg_word_reg, 16'hFFFF)
        @(posedge mclk);
        #1;
        rst_n = 1'b1;
        rd_chk(25'h0000010, arr(25'h0000010));
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Tests need well under 200 cycles
    initial
    begin
        #100000;
        n_mismatch++;
        end_of_test();
    end

    initial
    begin
        rst_n = 1'b0;
        req = '0;
        algo_busy = 16'h0000;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_idq();
        t_refuse();
        t_cfg();
        t_secure();
        t_rst_mid();
        end_of_test();
    end
endmodule
